/* File: verilog/dbgrd_pkg.sv */
// Package for the debug enclave read checker: leaf codes, page types, offsets and resets.
package dbgrd_pkg;
  localparam logic [31:0] DBGRD_LEAF_READ      = 32'h0000_0004;
  localparam logic [2:0]  DBGRD_PT_REGULAR     = 3'h0;
  localparam logic [2:0]  DBGRD_PT_THREAD_CTRL = 3'h1;
  localparam logic [2:0]  DBGRD_PT_VERSION_ARR = 3'h2;
  localparam logic [2:0]  DBGRD_PT_ENCL_CTRL   = 3'h3;
  localparam logic [11:0] DBGRD_PAGE_OFS_MASK  = 12'hFFF;
  localparam logic [63:0] DBGRD_SLOT_MASK      = 64'h0000_0000_0000_0007;
  localparam logic [11:0] DBGRD_THR_LIMIT_RST  = 12'h100;
  localparam logic [1:0]  DBGRD_RC_NONE        = 2'h0;
  localparam logic [1:0]  DBGRD_RC_NOT_DEBUG   = 2'h1;
  localparam logic [1:0]  DBGRD_FLT_NONE       = 2'h0;
  localparam logic [1:0]  DBGRD_FLT_GP         = 2'h1;
  localparam logic [1:0]  DBGRD_FLT_PF         = 2'h2;
  // Register byte offsets on the AHB-Lite slave.
  localparam logic [7:0]  DBGRD_OFS_CTRL       = 8'h00;
  localparam logic [7:0]  DBGRD_OFS_ACC        = 8'h04;
  localparam logic [7:0]  DBGRD_OFS_SRC_LO     = 8'h08;
  localparam logic [7:0]  DBGRD_OFS_SRC_HI     = 8'h0C;
  localparam logic [7:0]  DBGRD_OFS_RES_LO     = 8'h10;
  localparam logic [7:0]  DBGRD_OFS_RES_HI     = 8'h14;
  localparam logic [7:0]  DBGRD_OFS_STATUS     = 8'h18;
  localparam logic [7:0]  DBGRD_OFS_IRQ_STAT   = 8'h1C;
  localparam logic [7:0]  DBGRD_OFS_IRQ_MASK   = 8'h20;
  localparam logic [7:0]  DBGRD_OFS_THR_LIMIT  = 8'h24;
  localparam logic [7:0]  DBGRD_OFS_GO         = 8'h28;
  localparam logic [7:0]  DBGRD_OFS_FLT_LO     = 8'h2C;
  localparam logic [7:0]  DBGRD_OFS_FLT_HI     = 8'h30;
  // Control register fields.
  localparam int          DBGRD_CTRL_LMA       = 0;
  localparam int          DBGRD_CTRL_CODE_L    = 1;
  localparam int          DBGRD_CTRL_CPL_LO    = 2;
  localparam int          DBGRD_CTRL_SEG_BAD   = 4;
  // Interrupt status bits.
  localparam int          DBGRD_IRQ_DONE       = 0;
  localparam int          DBGRD_IRQ_GP         = 1;
  localparam int          DBGRD_IRQ_PF         = 2;
  localparam int          DBGRD_IRQ_NOTDBG     = 3;
  localparam logic [3:0]  DBGRD_IRQ_RST        = 4'h0;
  typedef enum logic [1:0] {
    DBGRD_IDLE  = 2'b00,
    DBGRD_MAP   = 2'b01,
    DBGRD_DATA  = 2'b10
  } dbgrd_state_t;
endpackage : dbgrd_pkg

/* File: verilog/dbgrd_core.sv */
// Debug enclave read checker with AHB-Lite registers and a page cache lookup port.
`timescale 1ns/1ps
// Summary of operation
// - Leaf value 04H in the accumulator selects the debug enclave read.
// - Eight bytes into full result in 64-bit mode, else four into low half.
// - 64-bit only when long mode active and code long flags both one.
// - Misaligned source (8 or 4 bytes per mode) gives protection fault code zero.
// - Source outside the protected page cache gives a page fault on that address.
// - Concurrent map-modifying instruction aborts the read with protection fault.
// - Invalid map entry for the source page gives a page fault.
// - Only regular, thread control or version array pages; others page fault.
// - Thread control page offset at or above size limit gives protection fault.
// - Regular or thread control pages need owning enclave debug set, then copy.
// - Version array slot with its low three bits (07H) cleared returns all ones if nonzero, else zero.
// - Read, write and execute map permissions are ignored.
// - Privilege level above zero or any segment violation faults.
// - Pending or modified page returns page-not-debuggable code without access.
// - Conflicting operations on the same page are refused, never run together.
// - Non-canonical source address in 64-bit mode gives protection fault.
module dbgrd_core
(
  input  wire logic                 hclk,          // Bus clock, 50 MHz.
  input  wire logic                 hresetn,       // Asynchronous reset, active low.
  input  wire logic                 hsel,          // Slave select.
  input  wire logic [7:0]           haddr,         // Byte address.
  input  wire logic [1:0]           htrans,        // Transfer type.
  input  wire logic                 hwrite,        // Write when high.
  input  wire logic [2:0]           hsize,         // Transfer size.
  input  wire logic [31:0]          hwdata,        // Write data.
  input  wire logic                 hready,        // Bus ready in.
  output logic                      hreadyout,     // Slave ready out.
  output logic                      hresp,         // Always OKAY.
  output logic [31:0]               hrdata,        // Read data.
  output logic                      map_req,       // Map and memory lookup request.
  output logic [63:0]               map_addr,      // Lookup address.
  input  wire logic                 map_ack,       // Lookup answer valid.
  input  wire logic                 map_in_cache,  // Address lies in the page cache.
  input  wire logic                 map_valid,     // Map entry valid.
  input  wire logic [2:0]           map_type,      // Map entry page type.
  input  wire logic                 map_pending,   // Page is pending.
  input  wire logic                 map_modified,  // Page is modified.
  input  wire logic                 map_debug,     // Owning enclave debug attribute.
  input  wire logic [63:0]          map_data,      // Memory doubleword at the address.
  input  wire logic                 map_busy,      // Other map-modifying instruction runs.
  input  wire logic                 page_conflict, // Conflicting operation on this page.
  output logic                      irq            // Level interrupt.
);
  import dbgrd_pkg::*;

  // How one leaf runs through this block.
  // Software writes the control flags, the leaf value and the source address,
  // then writes the start register.
  // The checks that need no lookup are done in the cycle after the start write.
  // They cover privilege, segment state, the canonical form and alignment.
  // If one of them fails, the fault is posted at once and no lookup is issued.
  // Otherwise one lookup goes out on the map port and the block waits for it.
  // The map port answers with the entry fields and the memory word together.
  // All later checks and the result are taken from that single answer.
  // The result register changes only when the leaf ends without a fault.
  // A not-debuggable page also leaves the result as it was.
  // Operand writes are refused while a lookup is pending.
  // This keeps the checks and the address that the map port sees consistent.
  // Software must not change operands and expect them to apply mid-leaf.
  // The page fault address is kept for software to read back.
  // It is only meaningful after a page fault; other outcomes leave it alone.
  // Every outcome raises the done status bit, so software may simply poll.
  // The block assumes that the map port keeps its answer for one cycle only.
  // Fields seen outside the acknowledge cycle are never used.
  // The map port is on the same clock, so its inputs need no synchroniser.
  // Conflicts with other page operations are reported by the map port.
  // The block turns them into a protection fault and touches nothing else.
  // Only one leaf can be in flight; a start while busy is ignored.
  // The leaf value must match exactly; any other value is a silent no-op.

  dbgrd_state_t state;
  logic [31:0]  ctrl;
  logic [31:0]  acc;
  logic [63:0]  src;
  logic [63:0]  result;
  logic [11:0]  thr_limit;
  logic [3:0]   irq_stat;
  logic [3:0]   irq_mask;
  logic [1:0]   fault;
  logic [1:0]   ret_code;
  logic [63:0]  fault_addr;
  logic         busy;
  logic         wide;
  logic         go;
  logic [1:0]   next_fault;
  logic [1:0]   next_rc;
  logic [63:0]  next_result;
  logic         done_ev;
  logic         ap_valid;
  logic         dp_write;
  logic         dp_read;
  logic [7:0]   dp_addr;
  logic [63:0]  slot;

  // Canonical check: upper bits all copies of bit 47.
  // The check is only applied in wide mode; narrow mode ignores the upper half.
  // Kept as a function so the rule reads the same wherever it is used.
  function automatic logic is_canonical(input logic [63:0] a);
    is_canonical = (a[63:47] == {17{a[47]}});
  endfunction : is_canonical

  // Width mode follows the captured control flags.
  // mode from flags
  assign wide = ctrl[DBGRD_CTRL_LMA] & ctrl[DBGRD_CTRL_CODE_L];

  // The slave always answers in zero wait states.
  // Every register is a flop or a simple mux, so no access needs a stall.
  // The response is fixed at OKAY; refused writes are dropped without an error.
  // Trading bus errors for silence keeps the slave trivial for software.
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign ap_valid  = hsel & htrans[1] & hready;
  assign go        = dp_write & (dp_addr == DBGRD_OFS_GO) & ~busy;

  // Address phase capture.
  // The write data only arrives in the following cycle, so the address and the
  // direction are held here until the data phase ends.
  // Reads decode the live address phase instead, so their data stands in the
  // data phase without an extra cycle.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_write <= 1'b0;
      dp_read  <= 1'b0;
      dp_addr  <= 8'h00;
    end
    else if (hready)
    begin
      dp_write <= ap_valid & hwrite;
      dp_read  <= ap_valid & ~hwrite;
      dp_addr  <= haddr;
    end
  end

  // Software-written registers; writes to operands are ignored while busy.
  // Refusing them avoids a change of mode or address while a lookup is out.
  // The interrupt mask is held too; software should set it before the start.
  // The size limit resets to a neutral default and may be rewritten.
  // Only the low twelve bits of the limit are kept, one page offset.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl      <= 32'h0000_0000;
      acc       <= 32'h0000_0000;
      src       <= 64'h0000_0000_0000_0000;
      thr_limit <= DBGRD_THR_LIMIT_RST;
      irq_mask  <= DBGRD_IRQ_RST;
    end
    else if (dp_write && !busy)
    begin
      if (dp_addr == DBGRD_OFS_CTRL)
        ctrl <= hwdata;
      else if (dp_addr == DBGRD_OFS_ACC)
        acc <= hwdata;
      else if (dp_addr == DBGRD_OFS_SRC_LO)
        src[31:0] <= hwdata;
      else if (dp_addr == DBGRD_OFS_SRC_HI)
        src[63:32] <= hwdata;
      else if (dp_addr == DBGRD_OFS_THR_LIMIT)
        thr_limit <= hwdata[11:0];
      else if (dp_addr == DBGRD_OFS_IRQ_MASK)
        irq_mask <= hwdata[3:0];
    end
  end

  // Read mux; unmapped offsets read as zero.
  // The data is registered at the address phase edge, so it stands for the
  // whole data phase and stays until the next read.
  // Status reads show the outcome of the last leaf until the next start.
  // The fault address words are only meaningful after a page fault.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (ap_valid && !hwrite)
    begin
      if (haddr == DBGRD_OFS_CTRL)
        hrdata <= ctrl;
      else if (haddr == DBGRD_OFS_ACC)
        hrdata <= acc;
      else if (haddr == DBGRD_OFS_SRC_LO)
        hrdata <= src[31:0];
      else if (haddr == DBGRD_OFS_SRC_HI)
        hrdata <= src[63:32];
      else if (haddr == DBGRD_OFS_RES_LO)
        hrdata <= result[31:0];
      else if (haddr == DBGRD_OFS_RES_HI)
        hrdata <= result[63:32];
      else if (haddr == DBGRD_OFS_STATUS)
        hrdata <= {24'h000000, busy, wide, ret_code, 2'b00, fault};
      else if (haddr == DBGRD_OFS_IRQ_STAT)
        hrdata <= {28'h0000000, irq_stat};
      else if (haddr == DBGRD_OFS_IRQ_MASK)
        hrdata <= {28'h0000000, irq_mask};
      else if (haddr == DBGRD_OFS_THR_LIMIT)
        hrdata <= {20'h00000, thr_limit};
      else if (haddr == DBGRD_OFS_FLT_LO)
        hrdata <= fault_addr[31:0];
      else if (haddr == DBGRD_OFS_FLT_HI)
        hrdata <= fault_addr[63:32];
      else
        hrdata <= 32'h0000_0000;
    end
  end

  // Checks without and with a lookup, in the order of precedence of the leaf.
  // In the idle state only the operand checks are evaluated.
  // In the lookup state the entry checks use the answer of the map port.
  // The first failing check wins, so later faults never mask earlier ones.
  // The result mux keeps the upper half in narrow mode.
  // The slot value is masked before its zero test.
  // Permission bits of the map entry are never consulted, so RWX cannot fault.
  // permissions ignored
  always_comb
  begin
    next_fault  = DBGRD_FLT_NONE;
    next_rc     = DBGRD_RC_NONE;
    next_result = result;
    slot        = map_data & ~DBGRD_SLOT_MASK;
    if (state == DBGRD_IDLE)
    begin
      if (ctrl[DBGRD_CTRL_CPL_LO +: 2] != 2'b00 || ctrl[DBGRD_CTRL_SEG_BAD])
        next_fault = DBGRD_FLT_GP;
      else if (wide && !is_canonical(src))
        next_fault = DBGRD_FLT_GP;
      else if (wide ? (src[2:0] != 3'b000) : (src[1:0] != 2'b00))
        next_fault = DBGRD_FLT_GP;
    end
    else
    begin
      if (!map_in_cache)
        next_fault = DBGRD_FLT_PF;
      else if (map_busy || page_conflict)
        next_fault = DBGRD_FLT_GP;
      else if (!map_valid)
        next_fault = DBGRD_FLT_PF;
      else if (map_type != DBGRD_PT_REGULAR && map_type != DBGRD_PT_THREAD_CTRL &&
               map_type != DBGRD_PT_VERSION_ARR)
        next_fault = DBGRD_FLT_PF;
      else if (map_type == DBGRD_PT_THREAD_CTRL && (src[11:0] & DBGRD_PAGE_OFS_MASK) >= thr_limit)
        next_fault = DBGRD_FLT_GP;
      else if (map_pending || map_modified)
        next_rc = DBGRD_RC_NOT_DEBUG;
      else if (map_type != DBGRD_PT_VERSION_ARR)
      begin
        if (!map_debug)
          next_fault = DBGRD_FLT_GP;
        else if (wide)
          next_result = map_data;
        else
          next_result = {result[63:32], map_data[31:0]};
      end
      else if (wide)
        next_result = (slot != 64'h0) ? 64'hFFFF_FFFF_FFFF_FFFF : 64'h0;
      else
        next_result = {result[63:32], (slot != 64'h0) ? 32'hFFFF_FFFF : 32'h0000_0000};
    end
  end

  // Operation sequencer; one lookup per issued leaf.
  // The request stays high until the acknowledge is seen, then drops at once.
  // The address given to the map port stays fixed for the whole lookup.
  // The done pulse is one cycle long and comes with the final outcome.
  // A hang of the map port holds the block busy; there is no local timeout.
  // Software that needs one must watch the busy bit itself.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state      <= DBGRD_IDLE;
      busy       <= 1'b0;
      map_req    <= 1'b0;
      map_addr   <= 64'h0;
      fault      <= DBGRD_FLT_NONE;
      ret_code   <= DBGRD_RC_NONE;
      result     <= 64'h0;
      fault_addr <= 64'h0;
      done_ev    <= 1'b0;
    end
    else
    begin
      done_ev <= 1'b0;
      case (state)
        DBGRD_IDLE:
        begin
          if (go && acc == DBGRD_LEAF_READ)
          begin
            fault    <= DBGRD_FLT_NONE;
            ret_code <= DBGRD_RC_NONE;
            if (next_fault != DBGRD_FLT_NONE)
            begin
              fault   <= next_fault;
              done_ev <= 1'b1;
            end
            else
            begin
              busy     <= 1'b1;
              map_req  <= 1'b1;
              map_addr <= src;
              state    <= DBGRD_MAP;
            end
          end
        end
        DBGRD_MAP:
        begin
          if (map_ack)
          begin
            map_req  <= 1'b0;
            busy     <= 1'b0;
            done_ev  <= 1'b1;
            fault    <= next_fault;
            ret_code <= next_rc;
            if (next_fault == DBGRD_FLT_PF)
              fault_addr <= src;
            if (next_fault == DBGRD_FLT_NONE && next_rc == DBGRD_RC_NONE)
              result <= next_result;
            state <= DBGRD_IDLE;
          end
        end
        default:
          state <= DBGRD_IDLE;
      endcase
    end
  end

  // Sticky interrupt status: write one to clear, a new event wins over the clear.
  // The set is applied after the clear, so an outcome that lands in the same
  // cycle as a clear is never lost.
  // The outcome bits are taken from the registered fault and return code.
  // They line up with the done pulse, which is registered at the same edge.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_stat <= DBGRD_IRQ_RST;
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (dp_write && dp_addr == DBGRD_OFS_IRQ_STAT && hwdata[i])
          irq_stat[i] <= 1'b0;
      end
      if (done_ev)
      begin
        irq_stat[DBGRD_IRQ_DONE] <= 1'b1;
        if (fault == DBGRD_FLT_GP)
          irq_stat[DBGRD_IRQ_GP] <= 1'b1;
        if (fault == DBGRD_FLT_PF)
          irq_stat[DBGRD_IRQ_PF] <= 1'b1;
        if (ret_code == DBGRD_RC_NOT_DEBUG)
          irq_stat[DBGRD_IRQ_NOTDBG] <= 1'b1;
      end
    end
  end

  // Level interrupt while any unmasked status bit is set.
  // It is a plain mix of registers, so it cannot glitch between edges.
  // Masking a set bit drops the line without clearing the status.
  // Software must clear the status bits to end the request for good.
  assign irq = |(irq_stat & irq_mask);
endmodule : dbgrd_core

/* File: sim/dbgrd_asserts.sv */
// Checker of bus and lookup handshake behaviour for the debug read block.
`timescale 1ns/1ps
module dbgrd_asserts
(
  input wire logic        hclk,      // Bus clock.
  input wire logic        hresetn,   // Reset, active low.
  input wire logic        hsel,      // Slave select.
  input wire logic [7:0]  haddr,     // Byte address.
  input wire logic [1:0]  htrans,    // Transfer type.
  input wire logic        hwrite,    // Write when high.
  input wire logic        hready,    // Bus ready.
  input wire logic        hreadyout, // Slave ready.
  input wire logic        hresp,     // Response.
  input wire logic [31:0] hrdata,    // Read data.
  input wire logic        map_req,   // Lookup request.
  input wire logic [63:0] map_addr,  // Lookup address.
  input wire logic        map_ack,   // Lookup answer.
  input wire logic        irq        // Interrupt.
);
  import dbgrd_pkg::*;
  logic rd_ph;
  logic go_ph;
  // Accepted read address phase and accepted start command.
  assign rd_ph = hsel & htrans[1] & ~hwrite & hready;
  assign go_ph = hsel & htrans[1] & hwrite & hready & (haddr == DBGRD_OFS_GO);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  a_ready_high: assert property (hreadyout == 1'b1) else $error("hreadyout low");
  a_resp_okay: assert property (hresp == 1'b0) else $error("hresp not okay");
  a_req_holds: assert property (map_req && !map_ack |=> map_req) else $error("lookup dropped");
  a_addr_stable: assert property (map_req && !map_ack |=> $stable(map_addr)) else $error("address moved");
  a_req_ends: assert property (map_req && map_ack |=> !map_req) else $error("lookup stuck");
  a_rdata_hold: assert property (!rd_ph |=> $stable(hrdata)) else $error("read data moved");
  a_addr_align: assert property ($rose(map_req) |-> map_addr[1:0] == 2'h0) else $error("misaligned lookup");
  a_req_from_go: assert property ($rose(map_req) |-> $past(go_ph, 2) || $past(go_ph, 3))
    else $error("lookup without start");
  c_lookup: cover property (map_req && map_ack);
  c_irq: cover property ($rose(irq));
  c_read: cover property (rd_ph);
endmodule : dbgrd_asserts

bind dbgrd_core dbgrd_asserts u_dbgrd_asserts (.*);

/* File: sim/dbgrd_map_model.sv */
// Behavioural page cache map that answers lookups after a chosen delay.
`timescale 1ns/1ps
module dbgrd_map_model
(
  input  wire logic        hclk,          // Bus clock.
  input  wire logic        hresetn,       // Reset, active low.
  input  wire logic        map_req,       // Lookup request.
  input  wire logic [2:0]  lat,           // Answer delay in cycles.
  input  wire logic [9:0]  ent,           // Entry fields set by the bench.
  input  wire logic [63:0] mem,           // Memory word at the address.
  output logic             map_ack,       // Answer valid.
  output logic             map_in_cache,  // In the page cache.
  output logic             map_valid,     // Entry valid.
  output logic [2:0]       map_type,      // Page type.
  output logic             map_pending,   // Page pending.
  output logic             map_modified,  // Page modified.
  output logic             map_debug,     // Debug attribute.
  output logic [63:0]      map_data,      // Memory data.
  output logic             map_busy,      // Map modifier running.
  output logic             page_conflict  // Conflict on this page.
);
  logic [3:0] cnt;
  // Count cycles of a pending lookup; a fresh one starts from zero.
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      cnt <= 4'h0;
    else
      cnt <= map_req ? cnt + 4'h1 : 4'h0;
  assign map_ack = map_req & (cnt == {1'b0, lat});
  // conflicts reported as commanded only in the answer cycle.
  // Outside the answer the fields are inverted, so a stale value is never trusted.
  assign {page_conflict, map_busy, map_debug, map_modified, map_pending, map_type, map_valid, map_in_cache,
          map_data} = map_ack ? {ent, mem} : ~{ent, mem};
endmodule : dbgrd_map_model

/* File: sim/dbgrd_core_tb.sv */
// Self-checking bench for the debug read block with a reference model.
`timescale 1ns/1ps
module dbgrd_core_tb;
  import dbgrd_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, map_req, map_ack, irq;
  logic map_in_cache, map_valid, map_pending, map_modified, map_debug, map_busy, page_conflict;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize, map_type, lat;
  logic [31:0] hwdata, hrdata, res_lo, res_hi, x, r;
  logic [63:0] map_addr, map_data, mem, s;
  logic [9:0] ent, f;
  logic [11:0] lim;
  integer error_cnt, tests_run, seed, cyc, i;
  assign hready = hreadyout;
  dbgrd_core u_dbgrd_core (.*);
  dbgrd_map_model u_dbgrd_map_model (.*);
  initial
  begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  task automatic close_out;
    $display("Counts: compares=%0d mismatches=%0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : close_out
  // A hang is cut short well after the expected run length.
  always @(posedge hclk)
  begin
    cyc = cyc + 1;
    if (cyc == 40000)
    begin
      error_cnt = error_cnt + 1;
      close_out;
    end
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp)
    begin
      error_cnt = error_cnt + 1;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    x = hrdata;
  endtask : bus
  task automatic run(input logic [4:0] c, input logic [63:0] a, input logic [63:0] d, input logic [3:0] m);
    logic w, gp, pf, nd;
    logic [63:0] v;
    w = c[0] & c[1];
    gp = 1'b0; pf = 1'b0; nd = 1'b0;
    if (c[3:2] != 2'h0 || c[4]) gp = 1'b1;
    else if (w && a[63:47] != {17{a[47]}}) gp = 1'b1;
    else if (w ? a[2:0] != 3'h0 : a[1:0] != 2'h0) gp = 1'b1;
    else if (!f[0]) pf = 1'b1;
    else if (f[8] | f[9]) gp = 1'b1;
    else if (!f[1]) pf = 1'b1;
    else if (f[4:2] > 3'h2) pf = 1'b1;
    else if (f[4:2] == 3'h1 && a[11:0] >= lim) gp = 1'b1;
    else if (f[5] | f[6]) nd = 1'b1;
    else if (f[4:2] != 3'h2 && !f[7]) gp = 1'b1;
    else
    begin
      v = (f[4:2] == 3'h2) ? {64{(d & ~64'h7) != 64'h0}} : d;
      res_lo = v[31:0];
      if (w) res_hi = v[63:32];
    end
    ent <= f; mem <= d;
    bus(DBGRD_OFS_CTRL, 1'b1, {27'h0, c});
    bus(DBGRD_OFS_ACC, 1'b1, DBGRD_LEAF_READ);
    bus(DBGRD_OFS_SRC_LO, 1'b1, a[31:0]);
    bus(DBGRD_OFS_SRC_HI, 1'b1, a[63:32]);
    bus(DBGRD_OFS_IRQ_MASK, 1'b1, {28'h0, m});
    bus(DBGRD_OFS_GO, 1'b1, 32'h0);
    do bus(DBGRD_OFS_IRQ_STAT, 1'b0, 32'h0); while (x[0] !== 1'b1);
    cmp(x, {28'h0, nd, pf, gp, 1'b1});
    cmp({31'h0, irq}, {31'h0, |({nd, pf, gp, 1'b1} & m)});
    bus(DBGRD_OFS_STATUS, 1'b0, 32'h0);
    cmp(x & 32'hF3, {25'h0, w, 1'b0, nd, 2'h0, pf, gp});
    bus(DBGRD_OFS_RES_LO, 1'b0, 32'h0);
    cmp(x, res_lo);
    bus(DBGRD_OFS_RES_HI, 1'b0, 32'h0);
    cmp(x, res_hi);
    if (pf)
    begin
      bus(DBGRD_OFS_FLT_LO, 1'b0, 32'h0);
      cmp(x, a[31:0]);
      bus(DBGRD_OFS_FLT_HI, 1'b0, 32'h0);
      cmp(x, a[63:32]);
    end
    bus(DBGRD_OFS_IRQ_STAT, 1'b1, 32'hF);
    bus(DBGRD_OFS_IRQ_STAT, 1'b0, 32'h0);
    cmp(x | {31'h0, irq}, 32'h0);
    $display("run done gp=%0d pf=%0d nd=%0d", gp, pf, nd);
  endtask : run
  initial
  begin
    hresetn = 1'b0; hsel = 1'b0; hwrite = 1'b0; haddr = 8'h0; htrans = 2'h0; hsize = 3'h2;
    hwdata = 32'h0; ent = 10'h0; mem = 64'h0; lat = 3'h0;
    error_cnt = 0; tests_run = 0; seed = 83; cyc = 0; res_lo = 32'h0; res_hi = 32'h0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    bus(DBGRD_OFS_THR_LIMIT, 1'b0, 32'h0);
    cmp(x, {20'h0, DBGRD_THR_LIMIT_RST});
    bus(8'h3C, 1'b1, 32'hFFFF_FFFF);
    bus(8'h3C, 1'b0, 32'h0);
    cmp(x, 32'h0);
    lim = 12'h0C8;
    bus(DBGRD_OFS_THR_LIMIT, 1'b1, {20'h0, lim});
    // Thread control page at and just below the size limit.
    f = 10'h087;
    run(5'h03, {52'h0, lim}, 64'h1234_5678_9ABC_DEF0, 4'hF);
    run(5'h03, {52'h0, lim - 12'h8}, 64'h1234_5678_9ABC_DEF0, 4'h1);
    for (i = 0; i < 60; i = i + 1)
    begin
      r = $random(seed);
      s = {$random(seed), $random(seed)};
      if (r[13:11] != 3'h0) s[63:47] = {17{s[46]}};
      if (r[15:14] != 2'h0) s[2:0] = 3'h0;
      f = 10'($random(seed));
      f = (f | {2'h0, r[23], 5'h0, r[16] | r[18], r[16] | r[17]}) &
          {r[24] & r[25], r[26] & r[27], 1'b1, r[21], r[22], r[19] & r[20], 4'hF};
      mem = {$random(seed), $random(seed)};
      if (r[28]) mem[63:3] = 61'h0;
      lat <= r[27:25];
      run({r[2:0] == 3'h0, (r[5:3] == 3'h0) ? r[7:6] : 2'h0, r[10] | r[9], r[8] | r[9]}, s, mem, r[31:28]);
    end
    // A start with another leaf value must do nothing.
    bus(DBGRD_OFS_ACC, 1'b1, 32'h5);
    bus(DBGRD_OFS_GO, 1'b1, 32'h0);
    repeat (3) bus(DBGRD_OFS_IRQ_STAT, 1'b0, 32'h0);
    cmp(x, 32'h0);
    close_out;
  end
endmodule : dbgrd_core_tb
